// [core/rsm_edge.sv]
// Either-edge detector for synchronous inputs
`timescale 1ns/1ps
`default_nettype none
module rsm_edge #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Inputs and edge pulses
  input  wire logic [WIDTH-1:0] sig,
  output logic      [WIDTH-1:0] pulse
);

  logic [WIDTH-1:0] prev_q;
  logic             primed_q;

  // First sample after reset only loads the history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q   <= '0;
      primed_q <= 1'b0;
    end else begin
      prev_q   <= sig;
      primed_q <= 1'b1;
    end
  end

  assign pulse = primed_q ? (sig ^ prev_q) : '0;

endmodule
`default_nettype wire

// [core/rsm_params.svh]
// Register indices, field layouts, reset values and masks of the runtime management block
`ifndef RSM_PARAMS_SVH
`define RSM_PARAMS_SVH

// Register indices; byte address is four times the index
`define RSM_IDX_STS3      8'h12
`define RSM_IDX_STS4      8'h13
`define RSM_IDX_STS5      8'h14
`define RSM_IDX_EN2       8'h17
`define RSM_IDX_EN3       8'h18
`define RSM_IDX_EN4       8'h19
`define RSM_IDX_EN5       8'h1A
`define RSM_IDX_RSVD_A    8'h1B
`define RSM_IDX_MSC       8'h1C
`define RSM_IDX_RSVD_B    8'h1D
`define RSM_IDX_FORCE     8'h1E
`define RSM_IDX_IRQ_STS   8'h30
`define RSM_IDX_IRQ_MASK  8'h31

// Writable bit masks
`define RSM_EN2_MASK      8'hF7
`define RSM_EN3_MASK      8'hF7
`define RSM_EN5_MASK      8'hCF
`define RSM_MSC_MASK      8'h3F
`define RSM_FORCE_MASK    8'h03
`define RSM_IRQ_MASK_W    8'h07

// Routing fields of enable register two
`define RSM_EN2_WAKE_BIT  5
`define RSM_EN2_SIRQ_BIT  6
`define RSM_EN2_PIN_BIT   7

// Interrupt status bits
`define RSM_IRQ_EDGE_BIT  0
`define RSM_IRQ_GRP_BIT   1
`define RSM_IRQ_MEDIA_BIT 2

// Reset values
`define RSM_EN_RESET      8'h00
`define RSM_STS_RESET     8'h00
`define RSM_FORCE_RESET   8'h01

`endif

// [core/rsm_pkg.sv]
// Types shared by the runtime management block
package rsm_pkg;

  typedef struct packed {
    logic gpio_pin_a;
    logic gpio_pin_b;
    logic gpio_pin_c;
    logic gpio_pin_d;
    logic gpio_pin_e;
    logic gpio_pin_f;
    logic gpio_pin_g;
    logic gpio_pin_h;
    logic gpio_pin_i;
    logic gpio_pin_j;
    logic gpio_pin_k;
    logic gpio_pin_l;
    logic gpio_pin_m;
    logic gpio_pin_n;
    logic gpio_pin_o;
    logic gpio_pin_p;
    logic gpio_pin_q;
    logic gpio_pin_r;
    logic gpio_pin_s;
  } rsm_gpio_type;

  typedef struct packed {
    logic group_wake_req;
    logic group_serial_irq_req;
    logic mgmt_irq_out_pin_n;
  } rsm_route_type;

endpackage

// [core/rsm_sticky.sv]
// Sticky status bits, set by hardware and cleared by writing one
`timescale 1ns/1ps
`default_nettype none
module rsm_sticky #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Set and clear
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  // State
  output logic      [WIDTH-1:0] q
);

  // A set in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= (q & ~clr) | set;
    end
  end

endmodule
`default_nettype wire

// [core/rsm_top.sv]
// Runtime management interrupt routing, edge status and forced media change
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rsm_params.svh"
module rsm_top (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // APB slave
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output logic      [31:0]          prdata,
  output logic                      pslverr,
  // Sources
  input  wire rsm_pkg::rsm_gpio_type gpio_in,
  input  wire logic                 fan_speed_input_a,
  input  wire logic                 fan_speed_input_b,
  // Floppy drive interface
  input  wire logic                 head_step_strobe_n,
  input  wire logic                 drive_select_a_n,
  input  wire logic                 drive_select_b_n,
  input  wire logic                 media_change_input_n,
  output logic                      media_change_flag,
  // Routed management interrupt
  output rsm_pkg::rsm_route_type    route_out,
  // Interrupt
  output logic                      irq
);

  // Reset release through two flops
  logic       rst_s1_q;
  logic       rst_n_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Bus decode
  logic [7:0] idx;
  logic       setup;
  logic       wr;
  logic [7:0] wdat;
  logic       mapped;
  assign idx   = paddr[9:2];
  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite && pstrb[0] && mapped;
  assign wdat  = pwdata[7:0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  always_comb begin
    unique case (idx)
      `RSM_IDX_STS3, `RSM_IDX_STS4, `RSM_IDX_STS5,
      `RSM_IDX_EN2, `RSM_IDX_EN3, `RSM_IDX_EN4, `RSM_IDX_EN5,
      `RSM_IDX_RSVD_A, `RSM_IDX_MSC, `RSM_IDX_RSVD_B, `RSM_IDX_FORCE,
      `RSM_IDX_IRQ_STS, `RSM_IDX_IRQ_MASK: mapped = (paddr[11:10] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Enable registers
  logic [7:0] en2_q;
  logic [7:0] en3_q;
  logic [7:0] en4_q;
  logic [7:0] en5_q;
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      en2_q <= `RSM_EN_RESET;
      en3_q <= `RSM_EN_RESET;
      en4_q <= `RSM_EN_RESET;
      en5_q <= `RSM_EN_RESET;
    end else if (wr && mapped) begin
      if (hit(idx, `RSM_IDX_EN2)) begin
        en2_q <= wdat & `RSM_EN2_MASK;
      end
      if (hit(idx, `RSM_IDX_EN3)) begin
        en3_q <= wdat & `RSM_EN3_MASK;
      end
      if (hit(idx, `RSM_IDX_EN4)) begin
        en4_q <= wdat;
      end
      if (hit(idx, `RSM_IDX_EN5)) begin
        en5_q <= wdat & `RSM_EN5_MASK;
      end
    end
  end

  // Source maps
  logic [7:0] src3;
  logic [7:0] src4;
  logic [7:0] src5;
  logic [5:0] edge_pins;
  assign src3 = {gpio_in.gpio_pin_g, gpio_in.gpio_pin_f, gpio_in.gpio_pin_e,
                 gpio_in.gpio_pin_d, 1'b0, gpio_in.gpio_pin_c,
                 gpio_in.gpio_pin_b, gpio_in.gpio_pin_a};
  assign src4 = {gpio_in.gpio_pin_o, gpio_in.gpio_pin_n, gpio_in.gpio_pin_m,
                 gpio_in.gpio_pin_l, gpio_in.gpio_pin_k, gpio_in.gpio_pin_j,
                 gpio_in.gpio_pin_i, gpio_in.gpio_pin_h};
  assign src5 = {fan_speed_input_b, fan_speed_input_a, 2'h0,
                 gpio_in.gpio_pin_s, gpio_in.gpio_pin_r,
                 gpio_in.gpio_pin_q, gpio_in.gpio_pin_p};
  assign edge_pins = {gpio_in.gpio_pin_o, gpio_in.gpio_pin_g, gpio_in.gpio_pin_n,
                      gpio_in.gpio_pin_l, gpio_in.gpio_pin_c, gpio_in.gpio_pin_b};

  // Latched management status
  logic [7:0] sts3;
  logic [7:0] sts4;
  logic [7:0] sts5;
  logic [7:0] clr3;
  logic [7:0] clr4;
  logic [7:0] clr5;
  assign clr3 = (wr && hit(idx, `RSM_IDX_STS3)) ? wdat : 8'h00;
  assign clr4 = (wr && hit(idx, `RSM_IDX_STS4)) ? wdat : 8'h00;
  assign clr5 = (wr && hit(idx, `RSM_IDX_STS5)) ? wdat : 8'h00;

  rsm_sticky #(.WIDTH(8)) u_sts3 (
    .clk   (clk),
    .rst_n (rst_n_q),
    .set   (src3),
    .clr   (clr3),
    .q     (sts3)
  );
  rsm_sticky #(.WIDTH(8)) u_sts4 (
    .clk   (clk),
    .rst_n (rst_n_q),
    .set   (src4),
    .clr   (clr4),
    .q     (sts4)
  );
  rsm_sticky #(.WIDTH(8)) u_sts5 (
    .clk   (clk),
    .rst_n (rst_n_q),
    .set   (src5),
    .clr   (clr5),
    .q     (sts5)
  );

  // Grouped management interrupt and its routes
  logic grp_d;
  logic grp_q;
  logic route_pin_q;
  logic route_sirq_q;
  logic route_wake_q;
  assign grp_d = |(sts3 & en3_q) | |(sts4 & en4_q) | |(sts5 & en5_q);
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      grp_q <= 1'b0;
    end else begin
      grp_q <= grp_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      route_pin_q  <= 1'b0;
      route_sirq_q <= 1'b0;
      route_wake_q <= 1'b0;
    end else begin
      route_pin_q  <= grp_d && en2_q[`RSM_EN2_PIN_BIT];
      route_sirq_q <= grp_d && en2_q[`RSM_EN2_SIRQ_BIT];
      route_wake_q <= grp_d && en2_q[`RSM_EN2_WAKE_BIT];
    end
  end
  assign route_out.mgmt_irq_out_pin_n   = !route_pin_q;
  assign route_out.group_serial_irq_req = route_sirq_q;
  assign route_out.group_wake_req       = route_wake_q;

  // Either-edge status
  logic [5:0] edge_pulse;
  logic [5:0] msc;
  logic [5:0] msc_clr;
  rsm_edge #(.WIDTH(6)) u_edge (
    .clk   (clk),
    .rst_n (rst_n_q),
    .sig   (edge_pins),
    .pulse (edge_pulse)
  );
  assign msc_clr = (wr && hit(idx, `RSM_IDX_MSC)) ? wdat[5:0] : 6'h00;
  rsm_sticky #(.WIDTH(6)) u_msc (
    .clk   (clk),
    .rst_n (rst_n_q),
    .set   (edge_pulse),
    .clr   (msc_clr),
    .q     (msc)
  );

  // Forced media change
  logic [1:0] force_q;
  logic [1:0] force_set;
  logic [1:0] force_clr;
  logic       sel_a;
  logic       sel_b;
  logic       step;
  assign sel_a = !drive_select_a_n;
  assign sel_b = !drive_select_b_n;
  assign step  = !head_step_strobe_n;
  assign force_set = (wr && hit(idx, `RSM_IDX_FORCE)) ? wdat[1:0] : 2'h0;
  assign force_clr = {step && sel_b, step && sel_a};
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      force_q <= 2'(`RSM_FORCE_RESET);
    end else begin
      force_q <= (force_q & ~force_clr) | force_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      media_change_flag <= 1'b0;
    end else begin
      media_change_flag <= (sel_a && force_q[0]) || (sel_b && force_q[1]) ||
                           !media_change_input_n;
    end
  end

  // Block interrupt
  logic [2:0] irq_sts;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [2:0] irq_mask_q;
  assign irq_set[`RSM_IRQ_EDGE_BIT]  = |edge_pulse;
  assign irq_set[`RSM_IRQ_GRP_BIT]   = grp_d && !grp_q;
  assign irq_set[`RSM_IRQ_MEDIA_BIT] = |(force_q & force_clr);
  assign irq_clr = (wr && hit(idx, `RSM_IDX_IRQ_STS)) ? wdat[2:0] : 3'h0;
  rsm_sticky #(.WIDTH(3)) u_irq (
    .clk   (clk),
    .rst_n (rst_n_q),
    .set   (irq_set),
    .clr   (irq_clr),
    .q     (irq_sts)
  );
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_mask_q <= 3'h0;
    end else if (wr && hit(idx, `RSM_IDX_IRQ_MASK)) begin
      irq_mask_q <= wdat[2:0] & 3'(`RSM_IRQ_MASK_W);
    end
  end
  assign irq = |(irq_sts & irq_mask_q);

  // Read data, captured in the setup cycle
  logic [7:0] rd_byte;
  always_comb begin
    unique case (idx)
      `RSM_IDX_STS3:     rd_byte = sts3;
      `RSM_IDX_STS4:     rd_byte = sts4;
      `RSM_IDX_STS5:     rd_byte = sts5;
      `RSM_IDX_EN2:      rd_byte = en2_q;
      `RSM_IDX_EN3:      rd_byte = en3_q;
      `RSM_IDX_EN4:      rd_byte = en4_q;
      `RSM_IDX_EN5:      rd_byte = en5_q;
      `RSM_IDX_MSC:      rd_byte = {2'h0, msc};
      `RSM_IDX_FORCE:    rd_byte = {6'h00, force_q};
      `RSM_IDX_IRQ_STS:  rd_byte = {5'h00, irq_sts};
      `RSM_IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask_q};
      default:           rd_byte = 8'h00;
    endcase
  end

  logic [31:0] prdata_q;
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end
  assign prdata = prdata_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  a_group_assert: assert property (grp_d |=> grp_q)
    else $error("group not asserted");
  a_group_block: assert property ((en3_q == 8'h00 && en4_q == 8'h00 &&
    en5_q == 8'h00) |=> !grp_q)
    else $error("group asserted with all enables off");
  a_pin_route: assert property (grp_d && en2_q[7] |=> !route_out.mgmt_irq_out_pin_n)
    else $error("pin not driven low");
  a_serial_route: assert property (!en2_q[6] |=> !route_out.group_serial_irq_req)
    else $error("serial request without enable");
  a_wake_route: assert property (grp_d && en2_q[`RSM_EN2_WAKE_BIT]
    |=> route_out.group_wake_req)
    else $error("wake request missing");
  a_rsvd_read: assert property (setup && !pwrite && (idx == 8'h1B || idx == 8'h1D)
    |=> prdata_q == 32'h0)
    else $error("reserved offset read not zero");
  a_msc_top_zero: assert property (setup && !pwrite && idx == 8'h1C
    |=> prdata_q[7:6] == 2'h0)
    else $error("edge status top bits not zero");
  a_en3_rsvd: assert property (!en3_q[3] && !en5_q[4] && !en5_q[5])
    else $error("reserved enable bit set");
  a_msc_clear: assert property (msc_clr[0] && !edge_pulse[0] |=> !msc[0])
    else $error("edge status not cleared");
  a_edge_set: assert property (edge_pins[1] != $past(edge_pins[1]) && $past(rst_n_q)
    |=> msc[1])
    else $error("edge status not set");
  a_force_keep: assert property (force_clr == 2'h0 |=> force_q[0] >= $past(force_q[0]))
    else $error("force bit cleared without step");
  a_step_clear: assert property (step && sel_a && force_set[0] == 1'b0 |=> !force_q[0])
    else $error("force bit not cleared on step");
  a_flag_or: assert property (!media_change_input_n |=> media_change_flag)
    else $error("media change input not passed");

endmodule
`default_nettype wire

// [dv/rsm_host_model.sv]
// Host side model that decodes the routed management interrupt
`timescale 1ns/1ps
`default_nettype none
module rsm_host_model (
  // Routed interrupt from the device
  input  wire rsm_pkg::rsm_route_type route_in,
  // Requests as the host sees them
  output logic                        wake_seen,
  output logic                        serial_seen,
  output logic                        pin_seen
);
  assign wake_seen   = route_in.group_wake_req;
  assign serial_seen = route_in.group_serial_irq_req;
  // Pin is active low at the host
  assign pin_seen    = ~route_in.mgmt_irq_out_pin_n;
endmodule
`default_nettype wire

// [dv/test_runtime_sysmgmt_irq_routing.sv]
// Testbench for the runtime management interrupt routing block
`timescale 1ns/1ps
`default_nettype none
`include "rsm_params.svh"
module test_runtime_sysmgmt_irq_routing;
  logic                   clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic [11:0]            paddr = 12'h000;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [31:0]            pwdata = 32'h0;
  logic [3:0]             pstrb = 4'hF;
  logic                   pready;
  logic [31:0]            prdata;
  logic                   pslverr;
  rsm_pkg::rsm_gpio_type  gpio_in = '0;
  logic                   fan_a = 1'b0;
  logic                   fan_b = 1'b0;
  logic                   step_n = 1'b1;
  logic                   sel_a_n = 1'b1;
  logic                   sel_b_n = 1'b1;
  logic                   chg_n = 1'b1;
  logic                   media_change_flag;
  rsm_pkg::rsm_route_type route_out;
  logic                   irq;
  logic                   wake_seen;
  logic                   serial_seen;
  logic                   pin_seen;
  logic [31:0]            rdv;
  logic                   erv;
  int                     errors = 0;
  int                     tests_run = 0;
  int                     cycles = 0;
  int                     pos [6] = '{17, 16, 7, 5, 12, 4};
  logic [7:0]             en2 [4] = '{8'h20, 8'h40, 8'h80, 8'hE0};

  always #2.5 clk = ~clk;

  rsm_top dut_u (
    .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .gpio_in(gpio_in), .fan_speed_input_a(fan_a),
    .fan_speed_input_b(fan_b), .head_step_strobe_n(step_n), .drive_select_a_n(sel_a_n),
    .drive_select_b_n(sel_b_n), .media_change_input_n(chg_n),
    .media_change_flag(media_change_flag), .route_out(route_out), .irq(irq)
  );

  rsm_host_model host_u (
    .route_in(route_out), .wake_seen(wake_seen), .serial_seen(serial_seen),
    .pin_seen(pin_seen)
  );

  task automatic stop_test;
    $display("errors %0d, tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      stop_test;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, i, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk(nm, {24'h0, e}, rdv);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset;
    rdchk("en3", `RSM_IDX_EN3, 8'h00);
    rdchk("en4", `RSM_IDX_EN4, 8'h00);
    rdchk("en5", `RSM_IDX_EN5, 8'h00);
    rdchk("edge_status", `RSM_IDX_MSC, 8'h00);
    rdchk("force", `RSM_IDX_FORCE, 8'h01);
    chk("route_out", 32'h1, {29'h0, route_out});
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_regs;
    apb(1'b1, `RSM_IDX_EN3, 8'hFF);
    rdchk("en3", `RSM_IDX_EN3, 8'hF7);
    apb(1'b1, `RSM_IDX_EN4, 8'hFF);
    rdchk("en4", `RSM_IDX_EN4, 8'hFF);
    apb(1'b1, `RSM_IDX_EN5, 8'hFF);
    rdchk("en5", `RSM_IDX_EN5, 8'hCF);
    apb(1'b1, `RSM_IDX_MSC, 8'hFF);
    rdchk("edge_status", `RSM_IDX_MSC, 8'h00);
    apb(1'b1, `RSM_IDX_RSVD_A, 8'hFF);
    rdchk("rsvd_a", `RSM_IDX_RSVD_A, 8'h00);
    rdchk("rsvd_b", `RSM_IDX_RSVD_B, 8'h00);
    rdchk("unmapped", 8'h40, 8'h00);
    chk("pslverr", 32'h1, {31'h0, erv});
    apb(1'b1, `RSM_IDX_EN3, 8'h00);
    apb(1'b1, `RSM_IDX_EN4, 8'h00);
    apb(1'b1, `RSM_IDX_EN5, 8'h00);
  endtask

  task automatic t_route;
    apb(1'b1, `RSM_IDX_EN3, 8'h01);
    gpio_in.gpio_pin_a <= 1'b1;
    @(posedge clk);
    gpio_in.gpio_pin_a <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `RSM_IDX_EN2, en2[k]);
      settle;
      chk("host_view", {29'h0, en2[k][7:5]}, {29'h0, pin_seen, serial_seen, wake_seen});
    end
    apb(1'b1, `RSM_IDX_EN3, 8'h00);
    settle;
    chk("host_view", 32'h0, {29'h0, pin_seen, serial_seen, wake_seen});
    rdchk("sts3", `RSM_IDX_STS3, 8'h01);
    apb(1'b1, `RSM_IDX_STS3, 8'h01);
    rdchk("sts3", `RSM_IDX_STS3, 8'h00);
    fan_b <= 1'b1;
    @(posedge clk);
    fan_b <= 1'b0;
    apb(1'b1, `RSM_IDX_EN5, 8'h80);
    settle;
    chk("host_view", 32'h7, {29'h0, pin_seen, serial_seen, wake_seen});
    apb(1'b1, `RSM_IDX_STS5, 8'h80);
    settle;
    chk("host_view", 32'h0, {29'h0, pin_seen, serial_seen, wake_seen});
    apb(1'b1, `RSM_IDX_EN2, 8'h00);
    apb(1'b1, `RSM_IDX_EN5, 8'h00);
  endtask

  task automatic t_edge;
    for (int b = 0; b < 6; b++) begin
      for (int lv = 1; lv >= 0; lv--) begin
        gpio_in[pos[b]] <= lv[0];
        settle;
        rdchk("edge_status", `RSM_IDX_MSC, 8'(1 << b));
        apb(1'b1, `RSM_IDX_MSC, 8'h00);
        rdchk("edge_status", `RSM_IDX_MSC, 8'(1 << b));
        apb(1'b1, `RSM_IDX_MSC, 8'(1 << b));
        rdchk("edge_status", `RSM_IDX_MSC, 8'h00);
      end
    end
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, `RSM_IDX_IRQ_MASK, 8'h01);
    settle;
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, `RSM_IDX_IRQ_STS, 8'h01);
    settle;
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_force;
    sel_a_n <= 1'b0;
    settle;
    chk("media_flag", 32'h1, {31'h0, media_change_flag});
    apb(1'b1, `RSM_IDX_FORCE, 8'h00);
    rdchk("force", `RSM_IDX_FORCE, 8'h01);
    apb(1'b1, `RSM_IDX_FORCE, 8'hFE);
    rdchk("force", `RSM_IDX_FORCE, 8'h03);
    step_n <= 1'b0;
    @(posedge clk);
    step_n <= 1'b1;
    settle;
    rdchk("force", `RSM_IDX_FORCE, 8'h02);
    chk("media_flag", 32'h0, {31'h0, media_change_flag});
    sel_a_n <= 1'b1;
    sel_b_n <= 1'b0;
    settle;
    chk("media_flag", 32'h1, {31'h0, media_change_flag});
    sel_b_n <= 1'b1;
    chg_n   <= 1'b0;
    settle;
    chk("media_flag", 32'h1, {31'h0, media_change_flag});
    chg_n   <= 1'b1;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_regs;
    t_route;
    t_edge;
    t_force;
    stop_test;
  end
endmodule
`default_nettype wire
